// File: core/als_irq_sleep_ctrl.sv
/*
 * Interrupt flags, enables, clear-on-read, sleep after interrupt,
 * oscillator gating and auto-zero interval of the light sensor.
 * Assumes a single-cycle register port from the serial host logic and
 * measurement events as one-cycle pulses on the same clock.
 */
// Notes on behaviour
// - Clear-on-read bit set: every status read clears all flags.
// - Oscillator off without power-on; stops if sleep bit and pin asserted.
// - Sleep condition checked when a measurement cycle completes.
// - Pin asserts for light, proximity or saturation flag, each with its enable.
// - Sleeping looks powered off, but power-on bit still reads one.
// - Only host clearing pending flags wakes the sleeping device.
// - Seven-bit auto-zero interval: zero never, n every nth, 7Fh first only.
// - Enable register: saturation enable bit 7, light enable bit 4, reset 0.
// - Writing one to a status flag clears it, whatever clear-on-read says.
// - Saturation flag bit 7 sets when the analog front end saturates.
// - Light flag bit 4 sets when results pass thresholds and persistence.
`timescale 1ns/100ps

module als_irq_sleep_ctrl
	import als_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [ALS_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [ALS_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [ALS_DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic meas_start_i,
	input wire logic meas_done_i,
	input wire logic sat_event_i,
	input wire logic light_event_i,
	input wire logic prox_event_i,
	input wire logic cal_event_i,
	output logic int_pad_o,
	output logic int_pad_oe_o,
	output logic osc_en_o,
	output logic az_run_o
);

	typedef struct packed {
		logic [7:0] power;
		logic [7:0] status;
		logic [7:0] irq_pwr_cfg;
		logic [7:0] az_cfg;
		logic [7:0] irq_en;
		logic sleeping;
		logic irq;
		logic osc;
		logic [7:0] rdata;
		logic rvalid;
	} als_ctrl_state_t;

	als_ctrl_state_t st;
	als_ctrl_state_t next_st;

	logic [7:0] set_bits;
	logic [7:0] clr_bits;
	logic host_clear;
	logic pending;
	logic power_on_bit;
	logic sleep_after_irq;

	// Flag pending terms and sleep decisions
	logic light_pend;
	logic prox_pend;
	logic sat_pend;
	logic sleep_enter;
	logic wake_now;

	assign power_on_bit = st.power[ALS_BIT_POWER_ON];
	assign sleep_after_irq = st.irq_pwr_cfg[ALS_BIT_SLEEP_AFTER_IRQ];

	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		set_bits = '0;
		clr_bits = '0;
		host_clear = 1'b0;

		// Flag sources
		set_bits[ALS_BIT_SAT_FLAG] = sat_event_i;
		set_bits[ALS_BIT_LIGHT_FLAG] = light_event_i;
		set_bits[ALS_BIT_PROX_FLAG] = prox_event_i;
		set_bits[ALS_BIT_CAL_FLAG] = cal_event_i;

		// Register writes, reserved bits stored as written
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ALS_OFS_POWER: begin
					next_st.power = reg_wdata_i;
				end
				ALS_OFS_STATUS: begin
					clr_bits = reg_wdata_i & ALS_STATUS_MASK;
					host_clear = |clr_bits;
				end
				ALS_OFS_IRQ_PWR_CFG: begin
					next_st.irq_pwr_cfg = reg_wdata_i;
				end
				ALS_OFS_AZ_CFG: begin
					next_st.az_cfg = reg_wdata_i;
				end
				ALS_OFS_IRQ_EN: begin
					next_st.irq_en = reg_wdata_i;
				end
				default: ;
			endcase
		end

		// Register reads, power-on bit reads as stored
		if (reg_rd_i) begin
			next_st.rvalid = 1'b1;
			unique case (reg_addr_i)
				ALS_OFS_POWER: begin
					next_st.rdata = st.power;
				end
				ALS_OFS_STATUS: begin
					next_st.rdata = st.status;
					if (st.irq_pwr_cfg[ALS_BIT_CLEAR_ON_READ]) begin
						clr_bits = ALS_STATUS_MASK;
						host_clear = 1'b1;
					end
				end
				ALS_OFS_IRQ_PWR_CFG: begin
					next_st.rdata = st.irq_pwr_cfg;
				end
				ALS_OFS_AZ_CFG: begin
					next_st.rdata = st.az_cfg;
				end
				ALS_OFS_IRQ_EN: begin
					next_st.rdata = st.irq_en;
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end

		// New events win over a clear in the same cycle
		for (int b = 0; b < ALS_DATA_W; b++) begin
			if (set_bits[b]) begin
				next_st.status[b] = 1'b1;
			end else if (clr_bits[b]) begin
				next_st.status[b] = 1'b0;
			end
		end
		next_st.status = next_st.status & ALS_STATUS_MASK;

		// Pin condition
		light_pend = next_st.status[ALS_BIT_LIGHT_FLAG]
			& next_st.irq_en[ALS_BIT_LIGHT_IRQ_EN];
		prox_pend = next_st.status[ALS_BIT_PROX_FLAG]
			& next_st.power[ALS_BIT_PROX_IRQ_EN];
		// Saturation with its enable also drives the pin
		sat_pend = next_st.status[ALS_BIT_SAT_FLAG]
			& next_st.irq_en[ALS_BIT_SAT_IRQ_EN];
		pending = light_pend | prox_pend | sat_pend;
		next_st.irq = pending;

		// Sleep entry at cycle completion
		sleep_enter = meas_done_i && power_on_bit && sleep_after_irq
			&& pending;
		// Host clear leaving nothing pending wakes
		wake_now = st.sleeping && host_clear && !pending;
		if (sleep_enter) begin
			next_st.sleeping = 1'b1;
		end else if (wake_now) begin
			next_st.sleeping = 1'b0;
		end

		// Oscillator gating, and
		next_st.osc = next_st.power[ALS_BIT_POWER_ON] && !next_st.sleeping;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st <= '{
				power: ALS_RST_POWER,
				status: ALS_RST_STATUS,
				irq_pwr_cfg: ALS_RST_IRQ_PWR_CFG,
				az_cfg: ALS_RST_AZ_CFG,
				irq_en: ALS_RST_IRQ_EN,
				sleeping: 1'b0,
				irq: 1'b0,
				osc: 1'b0,
				rdata: 8'h00,
				rvalid: 1'b0
			};
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// Auto-zero runs only while the oscillator runs
	als_autozero_sched #(
		.AZ_W(ALS_AZ_W)
	) u_az (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.power_on_i(st.osc),
		.cycle_start_i(meas_start_i),
		.autozero_interval_i(st.az_cfg[ALS_AZ_W-1:0]),
		.az_run_o(az_run_o)
	);

	// Open-drain pin: level held low, enable asserts it
	assign reg_rdata_o = st.rdata;
	assign reg_rvalid_o = st.rvalid;
	assign int_pad_o = 1'b0;
	assign int_pad_oe_o = st.irq;
	assign osc_en_o = st.osc;

endmodule

// File: core/als_pkg.sv
/*
 * Shared constants for the light-sensor interrupt and sleep control block.
 * Assumes an 8-bit register port driven by the serial host interface logic.
 */
package als_pkg;

	localparam int ALS_ADDR_W = 8;
	localparam int ALS_DATA_W = 8;
	localparam int ALS_AZ_W = 7;

	// Register offsets
	localparam logic [7:0] ALS_OFS_POWER = 8'h80;
	localparam logic [7:0] ALS_OFS_STATUS = 8'h93;
	localparam logic [7:0] ALS_OFS_IRQ_PWR_CFG = 8'hab;
	localparam logic [7:0] ALS_OFS_AZ_CFG = 8'hd6;
	localparam logic [7:0] ALS_OFS_IRQ_EN = 8'hdd;

	// Reset values
	localparam logic [7:0] ALS_RST_POWER = 8'h00;
	localparam logic [7:0] ALS_RST_STATUS = 8'h00;
	localparam logic [7:0] ALS_RST_IRQ_PWR_CFG = 8'h4c;
	localparam logic [7:0] ALS_RST_AZ_CFG = 8'h7f;
	localparam logic [7:0] ALS_RST_IRQ_EN = 8'h00;

	// Power register fields
	localparam int ALS_BIT_POWER_ON = 0;
	localparam int ALS_BIT_PROX_IRQ_EN = 5;

	// Status register fields
	localparam int ALS_BIT_SAT_FLAG = 7;
	localparam int ALS_BIT_PROX_FLAG = 5;
	localparam int ALS_BIT_LIGHT_FLAG = 4;
	localparam int ALS_BIT_CAL_FLAG = 3;
	localparam logic [7:0] ALS_STATUS_MASK = 8'hb8;

	// Configuration register fields
	localparam int ALS_BIT_CLEAR_ON_READ = 7;
	localparam int ALS_BIT_SLEEP_AFTER_IRQ = 4;

	// Interrupt enable fields
	localparam int ALS_BIT_SAT_IRQ_EN = 7;
	localparam int ALS_BIT_LIGHT_IRQ_EN = 4;

	// Auto-zero interval codes
	localparam logic [6:0] ALS_AZ_NEVER = 7'h00;
	localparam logic [6:0] ALS_AZ_FIRST_ONLY = 7'h7f;

endpackage

// File: core/als_autozero_sched.sv
/*
 * Auto-zero scheduler: decides, at each measurement cycle start, whether
 * auto-zero runs first. Assumes start pulses are on the same clock.
 */
`timescale 1ns/100ps

module als_autozero_sched
	import als_pkg::*;
#(
	parameter int AZ_W = ALS_AZ_W
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic power_on_i,
	input wire logic cycle_start_i,
	input wire logic [AZ_W-1:0] autozero_interval_i,
	output logic az_run_o
);

	typedef struct packed {
		logic [AZ_W-1:0] cnt;
		logic first;
		logic az;
	} als_az_state_t;

	als_az_state_t st;
	als_az_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.az = 1'b0;
		if (!power_on_i) begin
			next_st.first = 1'b1;
			next_st.cnt = '0;
		end else if (cycle_start_i) begin
			// Interval decode
			if (autozero_interval_i == AZ_W'(ALS_AZ_NEVER)) begin
				next_st.az = 1'b0;
			end else if (st.first) begin
				next_st.az = 1'b1;
				next_st.first = 1'b0;
				next_st.cnt = AZ_W'(1);
			end else if (autozero_interval_i == AZ_W'(ALS_AZ_FIRST_ONLY)) begin
				next_st.az = 1'b0;
			end else if (st.cnt >= autozero_interval_i) begin
				next_st.az = 1'b1;
				next_st.cnt = AZ_W'(1);
			end else begin
				next_st.cnt = st.cnt + AZ_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st <= '{cnt: '0, first: 1'b1, az: 1'b0};
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign az_run_o = st.az;

endmodule

// File: testbench/als_irq_asserts.sv
/* Checker on the block ports; assumes one clock and pulse strobes. */
`timescale 1ns/100ps
module als_irq_asserts (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic meas_start_i,
	input wire logic meas_done_i,
	input wire logic sat_event_i,
	input wire logic light_event_i,
	input wire logic prox_event_i,
	input wire logic cal_event_i,
	input wire logic int_pad_oe_o,
	input wire logic osc_en_o,
	input wire logic az_run_o
);
	logic [7:0] p, c, z, e;
	logic clr;
	wire w = ce_i && reg_wr_i;
	wire ev = sat_event_i | light_event_i | prox_event_i | cal_event_i;
	wire rs = ce_i && reg_rd_i && reg_addr_i == 8'h93;
	wire wc = w && reg_addr_i == 8'h93 && (reg_wdata_i & 8'hb8) == 8'hb8;
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			{p, c, z, e, clr} <= {32'h004c7f00, 1'b0};
		end else begin
			if (w && reg_addr_i == 8'h80) p <= reg_wdata_i;
			if (w && reg_addr_i == 8'hab) c <= reg_wdata_i;
			if (w && reg_addr_i == 8'hd6) z <= reg_wdata_i;
			if (w && reg_addr_i == 8'hdd) e <= reg_wdata_i;
			if (ce_i) clr <= !ev && (clr || (rs && c[7]) || wc);
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_idle;
		p[0] && !(ce_i && (reg_wr_i || reg_rd_i));
	endsequence
	sequence s_done_pend;
		ce_i && meas_done_i && p[0] && c[4] && int_pad_oe_o;
	endsequence
	chk_cleared_read:
	assert property (rs && clr |=> reg_rdata_o == 8'h00)
		else $error("flags not cleared");
	chk_osc_off:
	assert property (!p[0] ##1 !p[0] |-> !osc_en_o) else $error("osc on");
	chk_sleep_stop:
	assert property (s_done_pend |=> !osc_en_o) else $error("no sleep");
	chk_pin_raise:
	assert property (ce_i && (light_event_i && e[4] || sat_event_i && e[7]
		|| prox_event_i && p[5]) |=> int_pad_oe_o) else $error("pin low");
	chk_no_wake:
	assert property (s_idle ##1 s_idle ##0 !osc_en_o |=> !osc_en_o)
		else $error("woke alone");
	chk_pon_read:
	assert property (ce_i && reg_rd_i && reg_addr_i == 8'h80 && p[0]
		|=> reg_rdata_o[0]) else $error("power bit");
	chk_enable_read:
	assert property (ce_i && reg_rd_i && reg_addr_i == 8'hdd && !w
		|=> {reg_rdata_o[7], reg_rdata_o[4]} == {e[7], e[4]})
		else $error("enable bits");
	chk_az_never:
	assert property (ce_i && meas_start_i && z[6:0] == 7'h00 |=> !az_run_o)
		else $error("auto-zero");
endmodule
bind als_irq_sleep_ctrl als_irq_asserts u_als_irq_asserts (.*);

// File: testbench/als_host_model.sv
/* Host register master; assumes strobes taken at the rising edge. */
`timescale 1ns/100ps
module als_host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic rd_o
);
	initial {addr_o, wr_o, wdata_o, rd_o} = '0;
	// Flag clears and reserved fields as callers pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) #2;
		{addr_o, wdata_o, wr_o} = {a, d, 1'b1};
		@(posedge clk_sys_i) #2;
		{addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [8:0] q);
		@(posedge clk_sys_i) #2;
		{addr_o, rd_o} = {a, 1'b1};
		@(posedge clk_sys_i) #2;
		{addr_o, rd_o} = {~a, 1'b0};
		q = {rvalid_i, rdata_i};
	endtask
endmodule

// File: testbench/tb_top.sv
/* Self-checking bench; assumes the host model and checker files. */
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {logic [7:0] a; logic w; logic [15:0] dx;} als_row_t;
	logic clk_sys_i = 0, sys_rst_i = 1, ce_i = 1, meas_start_i = 0;
	logic meas_done_i = 0, sat_event_i = 0, light_event_i = 0;
	logic prox_event_i = 0, cal_event_i = 0, reg_wr_i, reg_rd_i;
	logic reg_rvalid_o, int_pad_o, int_pad_oe_o, osc_en_o, az_run_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [8:0] q;
	int err_count = 0, num_checks = 0, cyc = 0, azn = 0, az0 = 0;
	int aze [4] = '{0, 1, 3, 7};
	logic [6:0] azv [4] = '{7'h00, 7'h7f, 7'h03, 7'h01};
	als_row_t rows [8] = '{
		'{8'hab, 1'b0, 16'h004c},
		'{8'hd6, 1'b0, 16'h007f},
		'{8'hdd, 1'b0, 16'h0000},
		'{8'h93, 1'b0, 16'h0000},
		'{8'h10, 1'b1, 16'hff00},
		'{8'hdd, 1'b1, 16'h9090},
		'{8'hd6, 1'b1, 16'h0303},
		'{8'hab, 1'b1, 16'h4c4c}};
	als_irq_sleep_ctrl u_als_irq_sleep_ctrl (.*);
	als_host_model u_als_host_model (.clk_sys_i, .rdata_i(reg_rdata_o),
		.rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
		.wdata_o(reg_wdata_i), .rd_o(reg_rd_i));
	always #12.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (az_run_o === 1'b1) azn <= azn + 1;
		if (cyc == 3000) begin
			err_count++;
			complete_run;
		end
	end
	task automatic chk(input logic [8:0] s, input logic [8:0] x);
		num_checks++;
		if (s !== x) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk_sys_i) #2 s = 1;
		@(posedge clk_sys_i) #2 s = 0;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		#2 sys_rst_i = 0;
		foreach (rows[i]) begin
			if (rows[i].w) u_als_host_model.wr(rows[i].a, rows[i].dx[15:8]);
			u_als_host_model.rd(rows[i].a, q);
			chk(q, {1'b1, rows[i].dx[7:0]});
		end
		$display("table done");
		foreach (azv[i]) begin
			u_als_host_model.wr(8'h80, 8'h00);
			u_als_host_model.wr(8'hd6, {1'b0, azv[i]});
			u_als_host_model.wr(8'h80, 8'h01);
			az0 = azn;
			repeat (7) pulse(meas_start_i);
			repeat (2) @(posedge clk_sys_i);
			chk(9'(azn - az0), 9'(aze[i]));
		end
		$display("auto-zero done");
		u_als_host_model.wr(8'hdd, 8'h10);
		u_als_host_model.wr(8'hab, 8'h5c);
		pulse(light_event_i);
		chk(int_pad_oe_o, 9'h1);
		u_als_host_model.rd(8'h93, q);
		chk(q, 9'h110);
		pulse(meas_done_i);
		chk(osc_en_o, 9'h0);
		u_als_host_model.rd(8'h80, q);
		chk(q, 9'h101);
		repeat (6) pulse(meas_start_i);
		chk(osc_en_o, 9'h0);
		u_als_host_model.wr(8'h93, 8'hb8);
		@(posedge clk_sys_i) #2;
		chk({int_pad_oe_o, osc_en_o}, 9'h1);
		$display("sleep done");
		u_als_host_model.wr(8'hab, 8'hcc);
		u_als_host_model.wr(8'hdd, 8'h80);
		u_als_host_model.wr(8'h80, 8'h21);
		pulse(sat_event_i);
		chk(int_pad_oe_o, 9'h1);
		u_als_host_model.rd(8'h93, q);
		chk(q, 9'h180);
		u_als_host_model.rd(8'h93, q);
		chk(q, 9'h100);
		pulse(prox_event_i);
		chk(int_pad_oe_o, 9'h1);
		pulse(cal_event_i);
		u_als_host_model.rd(8'h93, q);
		chk(q, 9'h128);
		chk({int_pad_o, int_pad_oe_o}, 9'h0);
		@(posedge clk_sys_i) #2 sys_rst_i = 1;
		@(posedge clk_sys_i) #2 sys_rst_i = 0;
		chk({int_pad_oe_o, osc_en_o}, 9'h0);
		u_als_host_model.rd(8'hab, q);
		chk(q, 9'h14c);
		$display("reset done");
		complete_run;
	end
endmodule
